// File: logic/acra_pkg.sv
// constants, field layouts and carrier types of the converter clock and result alignment block
// assumes a classic wishbone master with 32-bit data and a converter core on the same clock
// Operation
// - prescale field 000/001/010/011 divide by 1/2/4/8; top bit set divides by 16
// - source select 1 takes bus clock, 0 takes crystal reference clock
// - reset clears source select, crystal reference clock by default
// - alignment 00 truncated, 01 right, 10 left, 11 left signed
// - reset sets alignment to right justified
// - truncated: bits 9..2 in low byte, high reads zero, no interlock
// - right justified: bits 9..8 in high bits 1..0, bits 7..0 in low
// - left justified: bits 9..2 high, bits 1..0 low top; signed inverts high msb
// - outside truncated, high read freezes low; results dropped until low read
package acra_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] HIGH_OFS  = 8'h04;
  localparam logic [7:0] LOW_OFS   = 8'h08;

  // ==========================================================
  // control field positions
  localparam int         RATIO_LSB = 5;
  localparam int         SRC_BIT   = 4;
  localparam int         ALIGN_LSB = 2;

  typedef enum logic [1:0] {
    ALIGN_TRUNC  = 2'h0,
    ALIGN_RIGHT  = 2'h1,
    ALIGN_LEFT   = 2'h2,
    ALIGN_SIGNED = 2'h3
  } acra_align_type;

  // ==========================================================
  // reset values
  localparam logic [2:0]     RATIO_RST = 3'h0;
  localparam logic           SRC_RST   = 1'b0;
  localparam acra_align_type ALIGN_RST = ALIGN_RIGHT;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } acra_result_type;

  typedef struct packed {
    logic [2:0]     ratio;
    logic           src;
    acra_align_type align;
  } acra_cfg_type;

  typedef struct packed {
    acra_cfg_type ctrl;
    acra_cfg_type act;
    logic [2:0]   xsync;
    logic [3:0]   cnt;
    logic         tick;
    logic [7:0]   high;
    logic [7:0]   low;
    logic         frozen;
    logic         ack;
    logic [31:0]  dat;
  } acra_state_type;

endpackage

// File: logic/acra_top.sv
// converter clock prescaler, source select and result packing with wishbone registers
// assumes conv_busy_i and conv_result_i come from the converter core on clk_i
`timescale 1ns/10ps
module acra_top (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic                     wb_we_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     crystal_reference_clock_i,
  input  wire logic                     conv_busy_i,
  input  wire acra_pkg::acra_result_type conv_result_i,
  output logic                          conv_tick_o
);

  // ==========================================================
  // state
  acra_pkg::acra_state_type s_ff;
  acra_pkg::acra_state_type nxt_s;

  function automatic logic [3:0] div_limit(input logic [2:0] ratio);
    unique case (ratio)
      3'h0:    div_limit = 4'h0;
      3'h1:    div_limit = 4'h1;
      3'h2:    div_limit = 4'h3;
      3'h3:    div_limit = 4'h7;
      default: div_limit = 4'hf;
    endcase
  endfunction

  logic       access;
  logic       rd_high;
  logic       rd_low;
  logic       src_tick;
  logic [7:0] ctrl_rd;
  logic [7:0] pk_high;
  logic [7:0] pk_low;

  // ==========================================================
  // next state
  always_comb begin
    nxt_s    = s_ff;
    access   = wb_cyc_i & wb_stb_i & ~s_ff.ack;
    rd_high  = access & ~wb_we_i & (wb_adr_i == acra_pkg::HIGH_OFS);
    rd_low   = access & ~wb_we_i & (wb_adr_i == acra_pkg::LOW_OFS);
    ctrl_rd  = {s_ff.ctrl.ratio, s_ff.ctrl.src, s_ff.ctrl.align, 2'h0};
    nxt_s.ack = access;
    nxt_s.dat = 32'h0;
    if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        acra_pkg::CTRL_OFS: nxt_s.dat = {24'h0, ctrl_rd};
        acra_pkg::HIGH_OFS: nxt_s.dat = {24'h0, (s_ff.act.align == acra_pkg::ALIGN_TRUNC) ? 8'h0 : s_ff.high};
        acra_pkg::LOW_OFS:  nxt_s.dat = {24'h0, s_ff.low};
        default:            nxt_s.dat = 32'h0;
      endcase
    end
    if (access && wb_we_i && wb_sel_i[0] && (wb_adr_i == acra_pkg::CTRL_OFS)) begin
      nxt_s.ctrl.ratio = wb_dat_i[acra_pkg::RATIO_LSB +: 3];
      nxt_s.ctrl.src   = wb_dat_i[acra_pkg::SRC_BIT];
      nxt_s.ctrl.align = acra_pkg::acra_align_type'(wb_dat_i[acra_pkg::ALIGN_LSB +: 2]);
    end
    // crystal pin synchroniser and edge
    nxt_s.xsync = {s_ff.xsync[1:0], crystal_reference_clock_i};
    src_tick    = s_ff.act.src ? 1'b1 : (s_ff.xsync[1] & ~s_ff.xsync[2]);
    nxt_s.tick  = 1'b0;
    if (!conv_busy_i && (s_ff.ctrl != s_ff.act)) begin
      nxt_s.act = s_ff.ctrl;
      nxt_s.cnt = 4'h0;
    end else if (src_tick) begin
      if (s_ff.cnt == div_limit(s_ff.act.ratio)) begin
        nxt_s.cnt  = 4'h0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 4'h1;
      end
    end
    // result packing
    pk_high = 8'h0;
    pk_low  = 8'h0;
    unique case (s_ff.act.align)
      acra_pkg::ALIGN_TRUNC: begin
        pk_low = conv_result_i.data[9:2];
      end
      acra_pkg::ALIGN_RIGHT: begin
        pk_high = {6'h0, conv_result_i.data[9:8]};
        pk_low  = conv_result_i.data[7:0];
      end
      acra_pkg::ALIGN_LEFT: begin
        pk_high = conv_result_i.data[9:2];
        pk_low  = {conv_result_i.data[1:0], 6'h0};
      end
      acra_pkg::ALIGN_SIGNED: begin
        pk_high = {~conv_result_i.data[9], conv_result_i.data[8:2]};
        pk_low  = {conv_result_i.data[1:0], 6'h0};
      end
    endcase
    // outside truncated, high read takes effect in its own cycle so a same-cycle result is dropped
    if (rd_high && s_ff.act.align != acra_pkg::ALIGN_TRUNC) begin
      nxt_s.frozen = 1'b1;
    end else if (rd_low) begin
      nxt_s.frozen = 1'b0;
    end
    if (conv_result_i.valid) begin
      if (s_ff.act.align == acra_pkg::ALIGN_TRUNC) begin
        nxt_s.high = 8'h0;
        nxt_s.low  = pk_low;
      end else if (!s_ff.frozen && !rd_high) begin
        nxt_s.high = pk_high;
        nxt_s.low  = pk_low;
      end
    end
    if (rst_i) begin
      nxt_s            = '0;
      // pin history kept so release brings no false edge
      nxt_s.xsync      = {s_ff.xsync[1:0], crystal_reference_clock_i};
      nxt_s.ctrl.ratio = acra_pkg::RATIO_RST;
      nxt_s.ctrl.src   = acra_pkg::SRC_RST;
      nxt_s.ctrl.align = acra_pkg::ALIGN_RST;
      nxt_s.act        = nxt_s.ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    s_ff <= nxt_s;
  end

  assign wb_dat_o    = s_ff.dat;
  assign wb_ack_o    = s_ff.ack;
  assign conv_tick_o = s_ff.tick;

  // ==========================================================
  // checks
  property p_cnt_bound;
    @(posedge clk_i) disable iff (rst_i)
      s_ff.cnt <= div_limit(s_ff.act.ratio);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("prescale count above divide limit");

  property p_tick_cause;
    @(posedge clk_i) disable iff (rst_i)
      $rose(conv_tick_o) |-> $past(s_ff.cnt) == div_limit($past(s_ff.act.ratio));
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("converter tick without full count");

  property p_div16;
    @(posedge clk_i) disable iff (rst_i)
      (conv_tick_o && s_ff.act.src && s_ff.act.ratio[2] && conv_busy_i) ##1 conv_busy_i[*8]
        |-> !conv_tick_o;
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 ticked early");

  property p_xtal_src;
    @(posedge clk_i) disable iff (rst_i)
      (!s_ff.act.src && conv_busy_i && $past(conv_busy_i) && s_ff.cnt != $past(s_ff.cnt))
        |-> $past(s_ff.xsync[1] & ~s_ff.xsync[2]);
  endproperty
  a_xtal_src: assert property (p_xtal_src) else $error("prescaler counted without crystal edge");

  property p_rst_src;
    @(posedge clk_i)
      rst_i |=> (s_ff.ctrl.src == 1'b0) && (s_ff.act.src == 1'b0);
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("source select not cleared by reset");

  property p_rst_align;
    @(posedge clk_i)
      rst_i |=> s_ff.ctrl.align == acra_pkg::ALIGN_RIGHT;
  endproperty
  a_rst_align: assert property (p_rst_align) else $error("alignment not right justified after reset");

  property p_trunc;
    @(posedge clk_i) disable iff (rst_i)
      (conv_result_i.valid && s_ff.act.align == acra_pkg::ALIGN_TRUNC)
        |=> s_ff.low == $past(conv_result_i.data[9:2]) && s_ff.high == 8'h0;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncated packing wrong");

  property p_right;
    @(posedge clk_i) disable iff (rst_i)
      (conv_result_i.valid && !s_ff.frozen && !rd_high && s_ff.act.align == acra_pkg::ALIGN_RIGHT)
        |=> {s_ff.high, s_ff.low} == {6'h0, $past(conv_result_i.data)};
  endproperty
  a_right: assert property (p_right) else $error("right justified packing wrong");

  property p_left;
    @(posedge clk_i) disable iff (rst_i)
      (conv_result_i.valid && !s_ff.frozen && !rd_high && s_ff.act.align[1])
        |=> {s_ff.high[6:0], s_ff.low} == {$past(conv_result_i.data[8:0]), 6'h0}
            && s_ff.high[7] == ($past(conv_result_i.data[9]) ^ $past(s_ff.act.align[0]));
  endproperty
  a_left: assert property (p_left) else $error("left justified packing wrong");

  property p_frozen;
    @(posedge clk_i) disable iff (rst_i)
      (s_ff.frozen && s_ff.act.align != acra_pkg::ALIGN_TRUNC) |=> $stable(s_ff.low);
  endproperty
  a_frozen: assert property (p_frozen) else $error("low byte changed while frozen");

  property p_hold_cfg;
    @(posedge clk_i) disable iff (rst_i)
      conv_busy_i |=> $stable(s_ff.act);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("active settings changed during conversion");

  property p_idle_load;
    @(posedge clk_i) disable iff (rst_i)
      (!conv_busy_i && s_ff.ctrl != s_ff.act) |=> s_ff.act == $past(s_ff.ctrl);
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("new settings not applied while idle");

  property p_trunc_high;
    @(posedge clk_i) disable iff (rst_i)
      (rd_high && s_ff.act.align == acra_pkg::ALIGN_TRUNC) |=> wb_dat_o == 32'h0;
  endproperty
  a_trunc_high: assert property (p_trunc_high) else $error("truncated high byte read not zero");

  property p_freeze_set;
    @(posedge clk_i) disable iff (rst_i)
      (rd_high && s_ff.act.align != acra_pkg::ALIGN_TRUNC) |=> s_ff.frozen;
  endproperty
  a_freeze_set: assert property (p_freeze_set) else $error("high byte read did not freeze low byte");

endmodule

// File: verif/tb_top.sv
// bench for the converter clock prescaler, source select and result packing block
// assumes the block answers wishbone requests and the bench acts as master and converter core
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic [7:0]                wb_adr_i = 8'h00;
  logic [31:0]               wb_dat_i = 32'h0;
  logic [3:0]                wb_sel_i = 4'h0;
  logic [3:0]                sel_v = 4'hf;
  logic                      wb_we_i = 1'b0;
  logic                      wb_cyc_i = 1'b0;
  logic                      wb_stb_i = 1'b0;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  logic                      conv_busy_i = 1'b0;
  acra_pkg::acra_result_type conv_result_i = '0;
  logic                      conv_tick_o;
  logic [2:0]                xcnt = 3'h0;
  int                        tick_total = 0;
  int                        bad_count = 0;
  int                        n_checks = 0;
  logic [31:0]               q;
  logic [9:0]                d;
  int                        dv;

  always #2 clk_i = ~clk_i;
  // crystal reference, one rising edge every 8 bus cycles
  always @(posedge clk_i) xcnt <= xcnt + 3'h1;
  always @(posedge clk_i) if (conv_tick_o === 1'b1) tick_total <= tick_total + 1;

  acra_top u_acra_top (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .wb_adr_i                  (wb_adr_i),
    .wb_dat_i                  (wb_dat_i),
    .wb_sel_i                  (wb_sel_i),
    .wb_we_i                   (wb_we_i),
    .wb_cyc_i                  (wb_cyc_i),
    .wb_stb_i                  (wb_stb_i),
    .wb_dat_o                  (wb_dat_o),
    .wb_ack_o                  (wb_ack_o),
    .crystal_reference_clock_i (xcnt[2]),
    .conv_busy_i               (conv_busy_i),
    .conv_result_i             (conv_result_i),
    .conv_tick_o               (conv_tick_o)
  );

  // ==========================================================
  // bus and converter tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_adr_i <= a; wb_we_i <= w; wb_dat_i <= wd; wb_sel_i <= sel_v;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    if (i == 20) begin
      bad_count++;
      $display("[ERR] ack exp 1 got timeout");
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] t;
    xfer(a, 1'b1, {24'h0, v}, t);
  endtask

  task automatic conv(input logic [9:0] v);
    @(posedge clk_i);
    conv_result_i <= '{valid: 1'b1, data: v};
    @(posedge clk_i);
    conv_result_i.valid <= 1'b0;
  endtask

  task automatic ticks(input string nm, input int n, input int ex);
    int s;
    repeat (4) @(posedge clk_i);
    s = tick_total;
    repeat (n) @(posedge clk_i);
    `CHK(nm, ex, tick_total - s)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(acra_pkg::CTRL_OFS, 1'b0, 32'h0, q); `CHK("ctrl reset", 32'h04, q)
    xfer(acra_pkg::HIGH_OFS, 1'b0, 32'h0, q); `CHK("high reset", 32'h0, q)
    ticks("crystal div1", 64, 8);
    $display("test reset done");
    wr(acra_pkg::CTRL_OFS, 8'hff);
    xfer(acra_pkg::CTRL_OFS, 1'b0, 32'h0, q); `CHK("ctrl rw", 32'hfc, q)
    wr(8'h0c, 8'h00);
    xfer(8'h0c, 1'b0, 32'h0, q); `CHK("unmapped", 32'h0, q)
    xfer(acra_pkg::CTRL_OFS, 1'b0, 32'h0, q); `CHK("ctrl kept", 32'hfc, q)
    sel_v = 4'he;
    wr(acra_pkg::CTRL_OFS, 8'h00);
    sel_v = 4'hf;
    xfer(acra_pkg::CTRL_OFS, 1'b0, 32'h0, q); `CHK("ctrl sel0 off", 32'hfc, q)
    wr(acra_pkg::HIGH_OFS, 8'hff);
    xfer(acra_pkg::HIGH_OFS, 1'b0, 32'h0, q); `CHK("high read only", 32'h0, q)
    $display("test register done");
    for (int r = 0; r < 8; r++) begin
      dv = r[2] ? 16 : (1 << r);
      wr(acra_pkg::CTRL_OFS, {r[2:0], 1'b1, 2'h1, 2'h0});
      ticks("bus prescale", 64, 64 / dv);
    end
    conv_busy_i <= 1'b1;
    ticks("busy div16", 64, 4);
    conv_busy_i <= 1'b0;
    wr(acra_pkg::CTRL_OFS, 8'h24);
    ticks("crystal div2", 128, 8);
    conv_busy_i <= 1'b1;
    wr(acra_pkg::CTRL_OFS, 8'h14);
    ticks("busy holds", 128, 8);
    conv_busy_i <= 1'b0;
    ticks("idle loads", 64, 64);
    $display("test prescale done");
    d = 10'h2d6;
    for (int m = 0; m < 4; m++) begin
      wr(acra_pkg::CTRL_OFS, {3'h0, 1'b1, m[1:0], 2'h0});
      conv(d);
      xfer(acra_pkg::HIGH_OFS, 1'b0, 32'h0, q);
      case (m)
        0: `CHK("trunc high", 32'h0, q)
        1: `CHK("right high", {30'h0, d[9:8]}, q)
        2: `CHK("left high", {24'h0, d[9:2]}, q)
        default: `CHK("signed high", {24'h0, ~d[9], d[8:2]}, q)
      endcase
      xfer(acra_pkg::LOW_OFS, 1'b0, 32'h0, q);
      case (m)
        0: `CHK("trunc low", {24'h0, d[9:2]}, q)
        1: `CHK("right low", {24'h0, d[7:0]}, q)
        default: `CHK("left low", {24'h0, d[1:0], 6'h0}, q)
      endcase
    end
    $display("test packing done");
    wr(acra_pkg::CTRL_OFS, 8'h14);
    conv(10'h155);
    xfer(acra_pkg::HIGH_OFS, 1'b0, 32'h0, q); `CHK("freeze high", 32'h1, q)
    conv(10'h2aa);
    xfer(acra_pkg::LOW_OFS, 1'b0, 32'h0, q); `CHK("frozen low", 32'h55, q)
    conv(10'h2aa);
    xfer(acra_pkg::LOW_OFS, 1'b0, 32'h0, q); `CHK("released low", 32'haa, q)
    wr(acra_pkg::CTRL_OFS, 8'h10);
    conv(10'h155);
    xfer(acra_pkg::HIGH_OFS, 1'b0, 32'h0, q); `CHK("trunc high zero", 32'h0, q)
    conv(10'h2aa);
    xfer(acra_pkg::LOW_OFS, 1'b0, 32'h0, q); `CHK("trunc no lock", 32'haa, q)
    $display("test freeze done");
    wr(acra_pkg::CTRL_OFS, 8'hfc);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(acra_pkg::CTRL_OFS, 1'b0, 32'h0, q); `CHK("ctrl second reset", 32'h04, q)
    xfer(acra_pkg::LOW_OFS, 1'b0, 32'h0, q); `CHK("low second reset", 32'h0, q)
    $display("test second reset done");
    close_out();
  end
endmodule
